// ==== common/glp_pkg.sv ====
// Shared constants, carriers and arithmetic for the ranged Galois LFSR generator.
package glp_pkg;

   // ==========================================================================
   // Widths and reset values
   // ==========================================================================
   localparam int unsigned STATE_W = 16;
   localparam int unsigned SPAN_W = STATE_W + 1;
   localparam int unsigned PROD_W = STATE_W + SPAN_W;
   localparam int unsigned SCALE_SHIFT = 16;
   localparam logic [STATE_W-1:0] FEEDBACK_POLY = 16'hB400;
   localparam logic [STATE_W-1:0] SEED_RST = 16'hACE1;
   localparam logic [STATE_W-1:0] LOWER_RST = 16'h0000;
   localparam logic [STATE_W-1:0] UPPER_RST = 16'hFFFF;
   localparam logic [STATE_W-1:0] RESULT_MASK = 16'hFFFF;

   // ==========================================================================
   // Carriers
   // ==========================================================================
   // One command word from the sequencer; any mix of strobes may be set.
   typedef struct packed {
      logic load_seed_cmd;
      logic read_random_cmd;
      logic set_range_cmd;
      logic [STATE_W-1:0] seed;
      logic [STATE_W-1:0] lower;
      logic [STATE_W-1:0] upper;
   } glp_cmd_s;

   // Answer to a read: valid strobe and scaled value.
   typedef struct packed {
      logic valid;
      logic [STATE_W-1:0] value;
   } glp_rand_s;

   // ==========================================================================
   // Arithmetic
   // ==========================================================================
   // One Galois step: take the low bit, shift right, fold in the polynomial.
   function automatic logic [STATE_W-1:0] lfsr_step(input logic [STATE_W-1:0] st);
      logic [STATE_W-1:0] sh;
      sh = st >> 1;
      lfsr_step = st[0] ? (sh ^ FEEDBACK_POLY) : sh;
   endfunction

   // Scale a state into [lower, upper]; the span is 17 bits wide so a full range fits.
   function automatic logic [STATE_W-1:0] scale_value(input logic [STATE_W-1:0] st,
                                                      input logic [STATE_W-1:0] lo,
                                                      input logic [STATE_W-1:0] hi);
      logic [SPAN_W-1:0] span;
      logic [PROD_W-1:0] prod;
      logic [SPAN_W-1:0] sum;
      span = {1'b0, hi} - {1'b0, lo} + 17'h00001;
      prod = {{SPAN_W{1'b0}}, st} * {{STATE_W{1'b0}}, span};
      sum = prod[PROD_W-1:SCALE_SHIFT] + {1'b0, lo};
      scale_value = sum[STATE_W-1:0] & RESULT_MASK;
   endfunction

endpackage

// ==== src/glp_range_scaler.sv ====
// Registered scaler that maps an LFSR state into the configured range.
`timescale 1ns/100ps
module glp_range_scaler (
   // Clock, reset and enable
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // Request with the freshly stepped state and the range in force
   input wire logic req_i,
   input wire logic [glp_pkg::STATE_W-1:0] state_i,
   input wire logic [glp_pkg::STATE_W-1:0] lower_i,
   input wire logic [glp_pkg::STATE_W-1:0] upper_i,
   // Registered answer
   output glp_pkg::glp_rand_s res_o
);

   glp_pkg::glp_rand_s res_r;
   glp_pkg::glp_rand_s res_nxt;

   // The value is held after the strobe drops so the reader may sample it late.
   always_comb begin
      res_nxt = res_r;
      res_nxt.valid = req_i;
      if (req_i) begin
         res_nxt.value = glp_pkg::scale_value(state_i, lower_i, upper_i);
      end
   end

   // The multiplier sits before this register, so the answer costs one cycle.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         res_r <= '0;
      end else if (clk_en_i) begin
         res_r <= res_nxt;
      end
   end

   assign res_o = res_r;

endmodule // glp_range_scaler

// ==== src/glp_pseudo_random_gen.sv ====
// Ranged pseudo-random generator built on a 16-bit Galois LFSR.
`timescale 1ns/100ps
module glp_pseudo_random_gen (
   // Clock, reset and enable
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // Commands from the sequencer
   input wire glp_pkg::glp_cmd_s cmd_i,
   // Random value answer
   output glp_pkg::glp_rand_s rand_o
);

   // ==========================================================================
   // State and range registers
   // ==========================================================================
   logic [glp_pkg::STATE_W-1:0] state_r;
   logic [glp_pkg::STATE_W-1:0] state_nxt;
   logic [glp_pkg::STATE_W-1:0] lower_r;
   logic [glp_pkg::STATE_W-1:0] lower_nxt;
   logic [glp_pkg::STATE_W-1:0] upper_r;
   logic [glp_pkg::STATE_W-1:0] upper_nxt;
   logic do_read;

   // A seed load wins over a read in the same cycle; that read is dropped.
   assign do_read = cmd_i.read_random_cmd & ~cmd_i.load_seed_cmd;

   // Next state: load, step, or hold.
   always_comb begin
      state_nxt = state_r;
      if (cmd_i.load_seed_cmd) begin
         state_nxt = cmd_i.seed;
      end else if (do_read) begin
         state_nxt = glp_pkg::lfsr_step(state_r);
      end
   end

   // Range update; a read in the same cycle still uses the old bounds.
   always_comb begin
      lower_nxt = lower_r;
      upper_nxt = upper_r;
      if (cmd_i.set_range_cmd) begin
         lower_nxt = cmd_i.lower;
         upper_nxt = cmd_i.upper;
      end
   end

   // Reset puts a nonzero seed in place so an unconfigured read is still useful.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= glp_pkg::SEED_RST;
         lower_r <= glp_pkg::LOWER_RST;
         upper_r <= glp_pkg::UPPER_RST;
      end else if (clk_en_i) begin
         state_r <= state_nxt;
         lower_r <= lower_nxt;
         upper_r <= upper_nxt;
      end
   end

   // ==========================================================================
   // Scaling stage
   // ==========================================================================
   // The stepped state feeds the scaler directly so the answer uses the new state.
   glp_range_scaler u_scaler (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .clk_en_i(clk_en_i),
      .req_i(do_read),
      .state_i(state_nxt),
      .lower_i(lower_r),
      .upper_i(upper_r),
      .res_o(rand_o)
   );

   // ==========================================================================
   // Assertions
   // ==========================================================================
   // Helper: set once any command has been taken since reset.
   logic cfg_seen_r;
   logic cfg_seen_nxt;

   // Tracks whether the sequencer has touched the block yet.
   always_comb begin
      cfg_seen_nxt = cfg_seen_r | cmd_i.load_seed_cmd | cmd_i.set_range_cmd | cmd_i.read_random_cmd;
   end

   // Registered only while enabled, like the rest of the state.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_seen_r <= 1'b0;
      end else if (clk_en_i) begin
         cfg_seen_r <= cfg_seen_nxt;
      end
   end

   property p_seed_load;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && cmd_i.load_seed_cmd) |=> (state_r == $past(cmd_i.seed));
   endproperty
   a_seed_load: assert property (p_seed_load) else $error("Seed was not loaded into the state.");

   property p_shift_plain;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && do_read && !state_r[0]) |=> (state_r == ($past(state_r) >> 1));
   endproperty
   a_shift_plain: assert property (p_shift_plain) else $error("Even state did not shift right by one.");

   property p_shift_poly;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && do_read && state_r[0]) |=> (state_r == (($past(state_r) >> 1) ^ glp_pkg::FEEDBACK_POLY));
   endproperty
   a_shift_poly: assert property (p_shift_poly) else $error("Odd state did not fold in the polynomial.");

   property p_answer_value;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && do_read) |=> (rand_o.valid &&
         rand_o.value == glp_pkg::scale_value(state_r, $past(lower_r), $past(upper_r)));
   endproperty
   a_answer_value: assert property (p_answer_value) else $error("Answer missing or wrongly scaled.");

   property p_no_spurious;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && !do_read) |=> !rand_o.valid;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("Answer strobe without a read.");

   property p_state_held;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (!clk_en_i || (!cmd_i.load_seed_cmd && !cmd_i.read_random_cmd)) |=> $stable(state_r);
   endproperty
   a_state_held: assert property (p_state_held) else $error("State changed between reads.");

   property p_range_store;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && cmd_i.set_range_cmd) |=> (lower_r == $past(cmd_i.lower) && upper_r == $past(cmd_i.upper));
   endproperty
   a_range_store: assert property (p_range_store) else $error("Range bounds were not stored.");

   property p_reset_default;
      @(posedge core_clk_i) disable iff (!nrst_i)
      !cfg_seen_r |-> (state_r == glp_pkg::SEED_RST && lower_r == glp_pkg::LOWER_RST &&
         upper_r == glp_pkg::UPPER_RST);
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("Reset defaults not in place.");

   property p_cov_read;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && do_read) ##1 (clk_en_i && do_read);
   endproperty
   c_cov_read: cover property (p_cov_read);

   property p_cov_poly;
      @(posedge core_clk_i) disable iff (!nrst_i)
      clk_en_i && do_read && state_r[0];
   endproperty
   c_cov_poly: cover property (p_cov_poly);

   property p_cov_range_read;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && cmd_i.set_range_cmd) ##1 (clk_en_i && do_read);
   endproperty
   c_cov_range_read: cover property (p_cov_range_read);

   property p_cov_seed_read;
      @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && cmd_i.load_seed_cmd) ##1 (clk_en_i && do_read);
   endproperty
   c_cov_seed_read: cover property (p_cov_seed_read);

endmodule // glp_pseudo_random_gen

// ==== verif/glp_seq_model.sv ====
// Sequencer model that issues seed, range and read commands to the generator.
`timescale 1ns/100ps
module glp_seq_model (
   // Clock
   input wire logic core_clk_i,
   // Command word towards the generator
   output glp_pkg::glp_cmd_s cmd_o
);
   // ==========================================================================
   // Command driver
   // ==========================================================================
   // Idle data fields invert so a stale field never passes for a held one.
   task automatic idle();
      cmd_o.load_seed_cmd = 1'b0;
      cmd_o.read_random_cmd = 1'b0;
      cmd_o.set_range_cmd = 1'b0;
      cmd_o.seed = ~cmd_o.seed;
      cmd_o.lower = ~cmd_o.lower;
      cmd_o.upper = ~cmd_o.upper;
   endtask
   // One word, held until the next call; a zero seed is never sent since it would lock the state.
   task automatic drive(input logic ld, input logic rd, input logic rg, input logic [15:0] s,
                        input logic [15:0] l, input logic [15:0] h);
      cmd_o = '{ld, rd, rg, (s === 16'h0000) ? 16'h0001 : s, l, h};
   endtask
   // Quiet word until the bench starts issuing.
   initial cmd_o = '0;
endmodule // glp_seq_model

// ==== verif/tb_top.sv ====
// Self-checking testbench for the ranged Galois LFSR generator.
`timescale 1ns/100ps
module tb_top;
   // ==========================================================================
   // Clock, reset and design
   // ==========================================================================
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic clk_en_i = 1'b1;
   glp_pkg::glp_cmd_s cmd;
   glp_pkg::glp_rand_s ans;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [15:0] st = glp_pkg::SEED_RST;
   logic [15:0] lo = 16'h0000;
   logic [15:0] hi = 16'hFFFF;
   // A 2 ns half period gives the 250 MHz core clock.
   always #2 core_clk_i = ~core_clk_i;
   glp_pseudo_random_gen DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .cmd_i(cmd), .rand_o(ans));
   glp_seq_model seq (.core_clk_i(core_clk_i), .cmd_o(cmd));
   // ==========================================================================
   // Reference arithmetic and checks
   // ==========================================================================
   // Independent model of one Galois step, written from the shift-and-fold rule.
   function automatic logic [15:0] e_step(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction
   // Wide arithmetic keeps the full-range span of 65536 exact.
   function automatic logic [15:0] e_scale(input logic [15:0] s, input logic [15:0] l, input logic [15:0] h);
      logic [63:0] span;
      span = 64'(h) - 64'(l) + 64'h1;
      return 16'(((64'(s) * span) >> 16) + 64'(l));
   endfunction
   // Case equality so that an unknown on the answer never passes.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One read; the caller idles the port once a burst ends.
   task automatic rd();
      seq.drive(1'b0, 1'b1, 1'b0, 16'h0001, lo, hi);
      st = e_step(st);
      @(posedge core_clk_i);
      #1;
      check({15'h0000, ans.valid}, 16'h0001);
      check(ans.value, e_scale(st, lo, hi));
   endtask
   task automatic done(input string name);
      seq.idle();
      @(posedge core_clk_i);
      #1;
      check({15'h0000, ans.valid}, 16'h0000);
      $display("Test %s finished, %0d checks so far", name, tests_run);
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_default();
      repeat (3) rd();
      done("default");
   endtask
   // Seeds with low bit set, top bit only, and all ones; reads run back to back.
   task automatic t_seed();
      logic [15:0] seeds [3] = '{16'h0001, 16'h8000, 16'hFFFF};
      foreach (seeds[i]) begin
         seq.drive(1'b1, 1'b0, 1'b0, seeds[i], lo, hi);
         st = seeds[i];
         @(posedge core_clk_i);
         #1;
         repeat (5) rd();
      end
      done("seed");
   endtask
   // Boundary ranges, then a range write beside a read that must use the old range.
   task automatic t_range();
      logic [15:0] ls [5] = '{16'h0000, 16'h0005, 16'h03E8, 16'hFFFF, 16'h0000};
      logic [15:0] hs [5] = '{16'h0000, 16'h0005, 16'h03EB, 16'hFFFF, 16'hFFFF};
      foreach (ls[i]) begin
         seq.drive(1'b0, 1'b0, 1'b1, 16'h0001, ls[i], hs[i]);
         lo = ls[i];
         hi = hs[i];
         @(posedge core_clk_i);
         #1;
         repeat (2) rd();
      end
      seq.drive(1'b0, 1'b1, 1'b1, 16'h0001, 16'h0010, 16'h001F);
      st = e_step(st);
      @(posedge core_clk_i);
      #1;
      check(ans.value, e_scale(st, lo, hi));
      lo = 16'h0010;
      hi = 16'h001F;
      rd();
      done("range");
   endtask
   // Seed and read together: the seed wins and no answer comes.
   task automatic t_clash();
      seq.drive(1'b1, 1'b1, 1'b0, 16'h1234, lo, hi);
      st = 16'h1234;
      @(posedge core_clk_i);
      #1;
      check({15'h0000, ans.valid}, 16'h0000);
      seq.idle();
      @(posedge core_clk_i);
      #1;
      rd();
      done("clash");
   endtask
   // A read offered while the enable is low must not step the state.
   task automatic t_enable();
      clk_en_i = 1'b0;
      seq.drive(1'b0, 1'b1, 1'b0, 16'h0001, lo, hi);
      repeat (3) @(posedge core_clk_i);
      #1;
      check({15'h0000, ans.valid}, 16'h0000);
      clk_en_i = 1'b1;
      seq.idle();
      @(posedge core_clk_i);
      #1;
      rd();
      done("enable");
   endtask
   // ==========================================================================
   // Main sequence and hang guard
   // ==========================================================================
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      #1;
      check({15'h0000, ans.valid}, 16'h0000);
      check(ans.value, 16'h0000);
      nrst_i = 1'b1;
      t_default();
      t_seed();
      t_range();
      t_clash();
      t_enable();
      results();
   end
endmodule // tb_top
